//--- i2c_master_model.sv
`timescale 1ns/10ps
module i2c_master_model (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Four cycles of 20 ns make a quarter of the 320 ns SCL period
    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask
    // Slave may stretch; bounded so a stuck bus ends at the watchdog
    task automatic release_scl();
        int k;
        scl_oe_o <= 1'b0;
        half();
        for (k = 0; k < 3000 && scl_i !== 1'b1; k++) begin
            @(posedge clk_i);
        end
    endtask
    // Works from idle and as a repeated start with SCL low
    task automatic start_cond();
        sda_oe_o <= 1'b0;
        half();
        release_scl();
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_oe_o <= 1'b1;
        half();
    endtask
    task automatic stop_cond();
        sda_oe_o <= 1'b1;
        half();
        release_scl();
        half();
        sda_oe_o <= 1'b0;
        half();
    endtask
    // SDA only moves while SCL is low, a quarter period after the fall
    task automatic clock_bit(input logic b, output logic r);
        sda_oe_o <= !b;
        half();
        release_scl();
        half();
        r = sda_i;
        scl_oe_o <= 1'b1;
        half();
    endtask
    task automatic send_byte(input logic [7:0] d);
        logic r;
        int i;
        for (i = 7; i >= 0; i--) begin
            clock_bit(d[i], r);
        end
    endtask
endmodule

//--- pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] pin_i,
    output logic [1:0] sync_o
);
    logic [1:0] meta;

    // Bus lines idle high, so reset to released level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 2'h3;
            sync_o <= 2'h3;
        end else begin
            meta <= pin_i;
            sync_o <= meta;
        end
    end
endmodule

//--- testbench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module testbench;
    import twi_pkg::*;
    logic clk, rst, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic pready, pslverr, irq, r;
    logic s_scl_oe, s_sda_oe, m_scl_oe, m_sda_oe;
    wire logic scl = !(m_scl_oe | s_scl_oe);
    wire logic sda = !(m_sda_oe | s_sda_oe);
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] holes [3] = '{FIFTH_LO, FIFTH_HI, 8'h18};

    two_wire_slave_flag_timing #(.TIMEOUT_CYCLES(200)) i_two_wire_slave_flag_timing (
        .clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl), .scl_o(),
        .scl_oe_o(s_scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(s_sda_oe), .irq_o(irq)
    );
    i2c_master_model i_i2c_master_model (
        .clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe)
    );

    task automatic final_report();
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Leaves psel high so a following transfer can go back to back
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            miscompares++;
            final_report();
        end
        q = prdata;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(CTRL_OFS, v);
        `CHK(v, {28'h0, CTRL_RST})
        rd(MASK_OFS, v);
        `CHK(v, {29'h0, MASK_RST})
        rd(ADDR_OFS, v);
        `CHK(v, {25'h0, ADDR_RST})
        `CHK(irq, 1'b0)
        wr(CTRL_OFS, 32'hFFFF_FFFF);
        rd(CTRL_OFS, v);
        `CHK(v, 32'h0000_000F)
        foreach (holes[i]) begin
            wr(holes[i], 32'hFFFF_FFFF);
            rd(holes[i], v);
            `CHK(v, 32'h0000_0000)
            `CHK(pslverr, 1'b0)
        end
        rd(CTRL_OFS, v);
        `CHK(v, 32'h0000_000F)
        wr(CTRL_OFS, 32'h0000_0001);
        wr(ADDR_OFS, 32'h0000_002A);
        wr(MASK_OFS, 32'h0000_0007);
        idle(2);
        // Foreign address first, then a repeated start to us
        i_i2c_master_model.start_cond();
        i_i2c_master_model.send_byte(8'h2A);
        `CHK(s_scl_oe, 1'b0)
        i_i2c_master_model.clock_bit(1'b1, r);
        `CHK(r, 1'b1)
        i_i2c_master_model.start_cond();
        i_i2c_master_model.send_byte(8'h54);
        `CHK(s_scl_oe, 1'b1)
        rd(STATUS_OFS, v);
        // Interrupt output lags the flag by one cycle
        `CHK(irq, 1'b1)
        `CHK(v[5:0], 6'h29)
        `CHK(v[7:6], BUS_BUSY)
        `CHK(scl, 1'b0)
        wr(MASK_OFS, 32'h0000_0000);
        idle(2);
        `CHK(irq, 1'b0)
        wr(MASK_OFS, 32'h0000_0007);
        wr(STATUS_OFS, 32'h0000_0001);
        rd(STATUS_OFS, v);
        `CHK(v[ST_HOLD_BIT], 1'b0)
        `CHK(v[ST_AP_BIT], 1'b0)
        idle(2);
        `CHK(s_scl_oe, 1'b0)
        `CHK(irq, 1'b0)
        i_i2c_master_model.clock_bit(1'b1, r);
        `CHK(r, 1'b0)
        i_i2c_master_model.send_byte(8'hA5);
        `CHK(s_scl_oe, 1'b1)
        rd(DATA_OFS, v);
        `CHK(irq, 1'b1)
        `CHK(v, 32'h0000_00A5)
        wr(CMD_OFS, {30'h0, CMD_RESPONSE});
        rd(STATUS_OFS, v);
        `CHK(v[ST_DIF_BIT], 1'b1)
        rd(STATUS_OFS, v);
        `CHK(v[ST_DIF_BIT], 1'b0)
        idle(1);
        i_i2c_master_model.clock_bit(1'b1, r);
        `CHK(r, 1'b0)
        i_i2c_master_model.stop_cond();
        idle(4);
        rd(STATUS_OFS, v);
        `CHK(v[ST_AP_BIT], 1'b1)
        `CHK(v[ST_ISADDR_BIT], 1'b0)
        `CHK(v[7:6], BUS_IDLE)
        `CHK(scl, 1'b1)
        wr(STATUS_OFS, 32'h0000_0007);
        // Bus left busy with SCL low and no stretch runs into the timeout
        wr(CTRL_OFS, 32'h0000_0003);
        idle(2);
        i_i2c_master_model.start_cond();
        rd(STATUS_OFS, v);
        `CHK(v[7:6], BUS_BUSY)
        idle(260);
        rd(STATUS_OFS, v);
        `CHK(v[7:6], BUS_IDLE)
        idle(1);
        i_i2c_master_model.stop_cond();
        final_report();
    end
endmodule

//--- twi_pkg.sv
package twi_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] ADDR_OFS = 8'h0C;
    localparam logic [7:0] DATA_OFS = 8'h10;
    localparam logic [7:0] MASK_OFS = 8'h14;
    // Window of the missing fifth-port instance
    localparam logic [7:0] FIFTH_LO = 8'h20;
    localparam logic [7:0] FIFTH_HI = 8'h3C;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TO_BIT = 1;
    localparam int CTRL_SDA_HOLD_SELECT_BIT = 2;
    localparam int CTRL_NACK_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    localparam int ST_AP_BIT = 0;
    localparam int ST_DIF_BIT = 1;
    localparam int ST_COLL_BIT = 2;
    localparam int ST_HOLD_BIT = 3;
    localparam int ST_DIR_BIT = 4;
    localparam int ST_ISADDR_BIT = 5;
    localparam int ST_BUS_LSB = 6;
    localparam int ST_SCL_BIT = 8;

    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [6:0] ADDR_RST = 7'h00;

    localparam logic [1:0] CMD_COMPLETE = 2'h2;
    localparam logic [1:0] CMD_RESPONSE = 2'h3;

    localparam logic [1:0] BUS_UNKNOWN = 2'h0;
    localparam logic [1:0] BUS_IDLE = 2'h1;
    localparam logic [1:0] BUS_BUSY = 2'h3;

    localparam int CLK_MHZ = 50;
    localparam int SDA_HOLD_NS = 300;
    localparam logic [4:0] SDA_HOLD_CYC = 5'((SDA_HOLD_NS * CLK_MHZ + 999) / 1000);
    localparam int TIMEOUT_US = 100;

    typedef enum logic [2:0] {
        IDLE, ADDR, WAIT_ADDR, ACK_OUT, RX, TX, TX_ACK, WAIT_DATA
    } slave_state_e;
endpackage

//--- two_wire_slave_flag_timing.sv
`timescale 1ns/10ps
module two_wire_slave_flag_timing
    import twi_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic irq_o
);
    logic [1:0] pins;
    logic scl_s, sda_s, scl_q, sda_q;
    logic [3:0] ctrl, next_ctrl;
    logic [2:0] mask, next_mask;
    logic [6:0] own_addr, next_own_addr;
    logic [7:0] tx_data, next_tx_data, rx_data, next_rx_data;
    logic [7:0] shreg, next_shreg;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [4:0] hold_cnt, next_hold_cnt;
    logic [12:0] to_cnt, next_to_cnt;
    logic [1:0] bus_cond, next_bus_cond;
    logic [31:0] next_prdata;
    logic ap_flag, dif_flag, coll_flag, hold, is_addr, dir, dif_clr_pend, sda_pend, sda_drv;
    logic next_ap_flag, next_dif_flag, next_coll_flag, next_hold, next_is_addr, next_dir;
    logic next_dif_clr_pend, next_sda_pend, next_sda_drv, next_irq;
    slave_state_e state, next_state;
    logic wr, scl_rise, scl_fall, start, stop, ap_clr, cmd_resp, cmd_done;
    logic ap_set, dif_set, coll_set, hold_set, timeout_hit, fifth_wr;

    pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({scl_i, sda_i}),
        .sync_o(pins)
    );
    assign scl_s = pins[1];
    assign sda_s = pins[0];

    assign pready_o = psel_i & penable_i;
    assign pslverr_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // SCL also held while a delayed SDA change is pending
    assign scl_oe_o = hold | (sda_pend != sda_drv);
    assign sda_oe_o = sda_drv;

    assign wr = psel_i & penable_i & pwrite_i;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start = scl_s & scl_q & sda_q & ~sda_s;
    assign stop = scl_s & scl_q & ~sda_q & sda_s;
    assign ap_clr = wr && paddr_i == STATUS_OFS && pwdata_i[ST_AP_BIT];
    assign cmd_resp = wr && paddr_i == CMD_OFS && pwdata_i[1:0] == CMD_RESPONSE;
    assign cmd_done = wr && paddr_i == CMD_OFS && pwdata_i[1:0] == CMD_COMPLETE;
    assign fifth_wr = wr && paddr_i >= FIFTH_LO && paddr_i <= FIFTH_HI;
    assign timeout_hit = ctrl[CTRL_TO_BIT] && bus_cond == BUS_BUSY && !hold
        && to_cnt == 13'(TIMEOUT_CYCLES - 1);

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_sda_pend = sda_pend;
        next_bus_cond = bus_cond;
        next_is_addr = is_addr;
        next_dir = dir;
        next_rx_data = rx_data;
        ap_set = 1'b0;
        dif_set = 1'b0;
        coll_set = 1'b0;
        hold_set = 1'b0;
        next_hold = hold;
        next_coll_flag = coll_flag;
        if (bus_cond == BUS_BUSY && !hold && !scl_rise && !scl_fall) begin
            next_to_cnt = to_cnt + 13'h0001;
        end else begin
            next_to_cnt = 13'h0000;
        end
        if (!ctrl[CTRL_EN_BIT]) begin
            next_state = IDLE;
            next_sda_pend = 1'b0;
            next_hold = 1'b0;
            next_bus_cond = BUS_UNKNOWN;
        end else if (timeout_hit) begin
            // A START in this very cycle is lost as well
            next_state = IDLE;
            next_bus_cond = BUS_IDLE;
            next_sda_pend = 1'b0;
        end else if (start) begin
            next_state = ADDR;
            next_bit_cnt = 4'h0;
            next_bus_cond = BUS_BUSY;
            next_sda_pend = 1'b0;
            next_hold = 1'b0;
            if (bus_cond != BUS_BUSY) begin
                next_coll_flag = 1'b0;
            end
        end else if (stop) begin
            next_state = IDLE;
            next_bus_cond = BUS_IDLE;
            next_sda_pend = 1'b0;
            next_hold = 1'b0;
            next_is_addr = 1'b0;
            ap_set = 1'b1;
        end else begin
            case (state)
                ADDR, RX: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        if (state == RX) begin
                            next_rx_data = shreg;
                            dif_set = 1'b1;
                            hold_set = 1'b1;
                            next_state = WAIT_DATA;
                        end else if (shreg[7:1] == own_addr) begin
                            ap_set = 1'b1;
                            hold_set = 1'b1;
                            next_is_addr = 1'b1;
                            next_dir = shreg[0];
                            next_state = WAIT_ADDR;
                        end else begin
                            next_state = IDLE;
                        end
                    end
                end
                WAIT_ADDR: begin
                    if (ap_clr) begin
                        next_sda_pend = 1'b1;
                        next_state = ACK_OUT;
                    end
                end
                ACK_OUT: begin
                    if (scl_fall) begin
                        next_bit_cnt = dir ? 4'h1 : 4'h0;
                        next_shreg = {tx_data[6:0], 1'b0};
                        next_sda_pend = dir & ~tx_data[7];
                        next_state = dir ? TX : RX;
                    end
                end
                TX: begin
                    if (scl_rise && !sda_drv && !sda_s) begin
                        coll_set = 1'b1;
                    end else if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            next_sda_pend = 1'b0;
                            next_state = TX_ACK;
                        end else begin
                            next_sda_pend = ~shreg[7];
                            next_shreg = {shreg[6:0], 1'b0};
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                TX_ACK: begin
                    if (scl_rise) begin
                        next_shreg[0] = sda_s;
                    end else if (scl_fall) begin
                        dif_set = !shreg[0];
                        hold_set = !shreg[0];
                        next_state = shreg[0] ? IDLE : WAIT_DATA;
                    end
                end
                WAIT_DATA: begin
                    if (cmd_resp) begin
                        next_hold = 1'b0;
                        next_sda_pend = dir ? 1'b0 : ~ctrl[CTRL_NACK_BIT];
                        next_state = ACK_OUT;
                    end else if (cmd_done) begin
                        next_hold = 1'b0;
                        next_state = IDLE;
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
        if (hold_set) begin
            // Clear colliding with a new address cannot win
            next_hold = 1'b1;
        end else if (ap_clr && state == WAIT_ADDR && !ap_set) begin
            next_hold = 1'b0;
        end
        if (coll_set) begin
            next_coll_flag = 1'b1;
        end else if (wr && paddr_i == STATUS_OFS && pwdata_i[ST_COLL_BIT]) begin
            next_coll_flag = 1'b0;
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        next_mask = mask;
        next_own_addr = own_addr;
        next_tx_data = tx_data;
        next_sda_drv = sda_drv;
        next_hold_cnt = 5'h00;
        // Writes into the fifth-port window are gated off and never reach the case
        if (wr && !fifth_wr) begin
            case (paddr_i)
                CTRL_OFS: next_ctrl = pwdata_i[3:0];
                ADDR_OFS: next_own_addr = pwdata_i[6:0];
                DATA_OFS: next_tx_data = pwdata_i[7:0];
                MASK_OFS: next_mask = pwdata_i[2:0];
                default: next_mask = mask;
            endcase
        end
        if (!ctrl[CTRL_EN_BIT]) begin
            next_sda_drv = 1'b0;
        end else if (sda_pend != sda_drv) begin
            if (!ctrl[CTRL_SDA_HOLD_SELECT_BIT] || hold_cnt == SDA_HOLD_CYC - 5'h01) begin
                next_sda_drv = sda_pend;
            end else begin
                next_hold_cnt = hold_cnt + 5'h01;
            end
        end
        next_ap_flag = ap_set | (ap_flag & ~ap_clr);
        next_dif_clr_pend = cmd_resp;
        if (dif_set) begin
            next_dif_flag = 1'b1;
        end else if (dif_clr_pend) begin
            next_dif_flag = 1'b0;
        end else if (wr && paddr_i == STATUS_OFS && pwdata_i[ST_DIF_BIT]) begin
            next_dif_flag = 1'b0;
        end else begin
            next_dif_flag = dif_flag;
        end
        next_irq = |({coll_flag, dif_flag, ap_flag} & mask);
        next_prdata = prdata_o;
        // Read data is captured in the setup cycle
        if (psel_i && !penable_i) begin
            case (paddr_i)
                CTRL_OFS: next_prdata = {28'h000_0000, ctrl};
                STATUS_OFS: next_prdata = {23'h00_0000, scl_s, bus_cond, is_addr, dir,
                    hold, coll_flag, dif_flag, ap_flag};
                ADDR_OFS: next_prdata = {25'h000_0000, own_addr};
                DATA_OFS: next_prdata = {24'h00_0000, rx_data};
                MASK_OFS: next_prdata = {29'h0000_0000, mask};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ctrl <= CTRL_RST;
            mask <= MASK_RST;
            own_addr <= ADDR_RST;
            tx_data <= 8'h00;
            rx_data <= 8'h00;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            hold_cnt <= 5'h00;
            to_cnt <= 13'h0000;
            bus_cond <= BUS_UNKNOWN;
            ap_flag <= 1'b0;
            dif_flag <= 1'b0;
            coll_flag <= 1'b0;
            hold <= 1'b0;
            is_addr <= 1'b0;
            dir <= 1'b0;
            dif_clr_pend <= 1'b0;
            sda_pend <= 1'b0;
            sda_drv <= 1'b0;
            state <= IDLE;
            prdata_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            ctrl <= next_ctrl;
            mask <= next_mask;
            own_addr <= next_own_addr;
            tx_data <= next_tx_data;
            rx_data <= next_rx_data;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            hold_cnt <= next_hold_cnt;
            to_cnt <= next_to_cnt;
            bus_cond <= next_bus_cond;
            ap_flag <= next_ap_flag;
            dif_flag <= next_dif_flag;
            coll_flag <= next_coll_flag;
            hold <= next_hold;
            is_addr <= next_is_addr;
            dir <= next_dir;
            dif_clr_pend <= next_dif_clr_pend;
            sda_pend <= next_sda_pend;
            sda_drv <= next_sda_drv;
            state <= next_state;
            prdata_o <= next_prdata;
            irq_o <= next_irq;
        end
    end

    sequence s_resp_cmd;
        cmd_resp && dif_flag && state == WAIT_DATA;
    endsequence
    sequence s_dif_late_clear;
        dif_flag ##1 !dif_flag;
    endsequence

    property p_addr_hold;
        @(posedge clk_i) disable iff (rst_i)
        ap_set && hold_set |=> ap_flag && hold && scl_oe_o;
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address without flag and hold");

    property p_clear_race;
        @(posedge clk_i) disable iff (rst_i)
        ap_set && hold_set && ap_clr |=> ap_flag && hold;
    endproperty
    a_clear_race: assert property (p_clear_race) else $error("colliding clear lost the set");

    property p_timeout_start;
        @(posedge clk_i) disable iff (rst_i)
        timeout_hit && start && ctrl[CTRL_EN_BIT] |=> state == IDLE && bus_cond == BUS_IDLE;
    endproperty
    a_timeout_start: assert property (p_timeout_start) else $error("start kept at timeout");

    property p_dif_clear;
        @(posedge clk_i) disable iff (rst_i)
        s_resp_cmd |=> s_dif_late_clear;
    endproperty
    a_dif_clear: assert property (p_dif_clear) else $error("data flag clear timing wrong");

    property p_sda_hold;
        @(posedge clk_i) disable iff (rst_i)
        $changed(sda_drv) && ctrl[CTRL_SDA_HOLD_SELECT_BIT] && $past(ctrl[CTRL_SDA_HOLD_SELECT_BIT])
            && $past(ctrl[CTRL_EN_BIT]) |-> $past(hold_cnt) == SDA_HOLD_CYC - 5'h01;
    endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("sda changed before hold time");

    property p_fifth_write;
        @(posedge clk_i) disable iff (rst_i)
        fifth_wr |=> $stable(ctrl) && $stable(mask) && $stable(own_addr) && $stable(tx_data);
    endproperty
    a_fifth_write: assert property (p_fifth_write) else $error("fifth-port write had effect");

    property p_coll_rep_start;
        @(posedge clk_i) disable iff (rst_i)
        start && bus_cond == BUS_BUSY && coll_flag && ctrl[CTRL_EN_BIT] && !timeout_hit
            && !(wr && paddr_i == STATUS_OFS && pwdata_i[ST_COLL_BIT]) |=> coll_flag;
    endproperty
    a_coll_rep_start: assert property (p_coll_rep_start) else $error("collision cleared");

    property p_release;
        @(posedge clk_i) disable iff (rst_i)
        ap_clr && !ap_set && state == WAIT_ADDR && ctrl[CTRL_EN_BIT] && !start && !stop
            && !timeout_hit |=> !hold ##1 !scl_oe_o || sda_pend != sda_drv;
    endproperty
    a_release: assert property (p_release) else $error("flag clear did not release scl");
endmodule
